//--- verilog/temp_seq_ctrl.sv
// Conversion sequencer, limit comparison and pointer register file of
// a nine-channel temperature monitor, with a two-wire host link port.
// Assumes an analog front end on core_clk and a host on linkClk.
`include "temp_seq_defs.svh"

// Overview of operation
// - Limit status at 22h, remote 15:8, local 7
// - Flag set when temperature exceeds channel limit
// - Flag clears at or below limit minus half the hysteresis value
// - Active-low output low while any flag set
// - Open status at 23h, bits 15:8, rest zero
// - Open flags never drive overtemperature output
// - Configuration at 30h, resets to 0F9C
// - Disabled channels are skipped by sequencer
// - Order local, remote one to eight, wrap
// - No channel enabled acts as plain shutdown
// - Shutdown clear means continuous paced conversion
// - Shutdown write aborts conversion at once
// - Leaving shutdown restarts at lowest enabled channel
// - Busy bit shows converter activity, ignores writes
// - One-shot in shutdown runs one pass
// - Shutdown plus one-shot with enables selects pass
// - Rate field sets idle interval only
// - Cycle length scales with enabled channels
// - Result refreshed per conversion, zero before
module temp_seq_ctrl
    import temp_seq_pkg::*;
#(
    parameter int unsigned LOC_CONV_CYC = `LOC_CONV_US * `CLK_MHZ,
    parameter int unsigned REM_CONV_CYC = `REM_CONV_US * `CLK_MHZ,
    parameter int unsigned QUARTER_CYC  = `QUARTER_SEC_US * `CLK_MHZ
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        linkClk,
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic        cmdPtrOnly,
    input  wire logic [7:0]  cmdAddr,
    input  wire logic [15:0] cmdData,
    output logic             cmdReady,
    output logic             rspValid,
    output logic [15:0]      rspData,
    output logic             feStart,
    output logic [3:0]       feChan,
    input  wire logic [12:0] feResult,
    input  wire logic        feOpen,
    output logic             secondOvertempN
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic        cmdReady_r, rspValid_r, reqTgl_r, ackSync1_r, ackSync2_r;
    logic        ackSeen_r, lWrite_r, lPtrOnly_r;
    logic [7:0]  lAddr_r;
    logic [15:0] lData_r, rspData_r;
    logic        reqSync1_r, reqSync2_r, reqSeen_r, ackTgl_r;
    logic [7:0]  pointer_r;
    logic [15:0] rspWord_r, readWord;
    logic [15:0] cfg_r, hyst_r;
    logic [15:0] limit_r [0:8];
    logic [12:0] result_r [0:8];
    logic [8:0]  flags_r, flagsNxt, enPrev_r;
    logic [8:1]  openFlags_r;
    logic        osPend_r, oneShotPass_r, feStart_r, secondOvertempN_r;
    seq_state_t  state_r;
    logic [3:0]  chan_r, doneChan_r, startChan, nextChan;
    logic [31:0] cnt_r, age_r;
    logic        cmdTake, wrTake, cfgWr, anyEn, runCont, abort;
    logic        convDone, startPass, startConv, overNow, underNow;
    logic [8:0]  en9;
    logic [2:0]  rate;
    logic [4:0]  wrSlot, rdSlot;
    logic [15:0] tempWord;
    logic [16:0] clearLevel;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Lowest enabled channel at or above a start index, F when none
    function automatic logic [3:0] firstFrom(input logic [8:0] en,
                                             input logic [3:0] from);
        firstFrom = 4'hF;
        for (int i = 8; i >= 0; i--) begin
            if (en[i] && (4'(i) >= from)) begin
                firstFrom = 4'(i);
            end
        end
    endfunction

    // Limit register slot for a pointer: hit bit and channel index
    function automatic logic [4:0] limitSlot(input logic [7:0] a);
        limitSlot = 5'h00;
        if (a == `PTR_LOCAL_LIMIT) begin
            limitSlot = 5'h10;
        end
        for (int i = 1; i <= 8; i++) begin
            if (a == 8'(`PTR_REMOTE_LIMIT1 + (i - 1) * `REMOTE_LIMIT_STEP)) begin
                limitSlot = {1'b1, 4'(i)};
            end
        end
    endfunction

    // Conversion length of one channel
    function automatic logic [31:0] convCycles(input logic [3:0] c);
        convCycles = (c == 4'h0) ? 32'(LOC_CONV_CYC) : 32'(REM_CONV_CYC);
    endfunction

    // ----------------------------------------------------------------
    // Link domain: command capture and toggle handshake
    // ----------------------------------------------------------------
    // One command in flight; ready returns when the core acknowledges
    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            cmdReady_r <= 1'b1;
            rspValid_r <= 1'b0;
            rspData_r  <= 16'h0000;
            reqTgl_r   <= 1'b0;
            ackSync1_r <= 1'b0;
            ackSync2_r <= 1'b0;
            ackSeen_r  <= 1'b0;
            lWrite_r   <= 1'b0;
            lPtrOnly_r <= 1'b0;
            lAddr_r    <= 8'h00;
            lData_r    <= 16'h0000;
        end else begin
            ackSync1_r <= ackTgl_r;
            ackSync2_r <= ackSync1_r;
            rspValid_r <= 1'b0;
            if (cmdValid && cmdReady_r) begin
                lWrite_r   <= cmdWrite;
                lPtrOnly_r <= cmdPtrOnly;
                lAddr_r    <= cmdAddr;
                lData_r    <= cmdData;
                reqTgl_r   <= ~reqTgl_r;
                cmdReady_r <= 1'b0;
            end
            if (ackSync2_r != ackSeen_r) begin
                ackSeen_r  <= ackSync2_r;
                cmdReady_r <= 1'b1;
                rspValid_r <= 1'b1;
                rspData_r  <= rspWord_r;  // Held stable by the core
            end
        end
    end

    assign cmdReady = cmdReady_r;
    assign rspValid = rspValid_r;
    assign rspData  = rspData_r;

    // ----------------------------------------------------------------
    // Core domain: request pickup, pointer and reads
    // ----------------------------------------------------------------
    assign cmdTake = (reqSync2_r != reqSeen_r);
    assign wrTake  = cmdTake && lWrite_r && !lPtrOnly_r;
    assign cfgWr   = wrTake && (lAddr_r == `PTR_CONFIG);
    assign wrSlot  = limitSlot(lAddr_r);
    assign rdSlot  = limitSlot(pointer_r);

    // Read data for the current pointer; unassigned pointers read zero
    always_comb begin
        readWord = 16'h0000;
        if (pointer_r <= `PTR_RESULT_LAST) begin
            readWord = {result_r[pointer_r[3:0]], 3'b000};
        end else if (pointer_r == `PTR_LIMIT_STATUS) begin
            readWord = {flags_r[8:1], flags_r[0], 7'h00};
        end else if (pointer_r == `PTR_OPEN_STATUS) begin
            readWord = {openFlags_r, 8'h00};
        end else if (pointer_r == `PTR_CONFIG) begin
            readWord = {cfg_r[15:2], state_r == SEQ_CONV, 1'b0};
        end else if (pointer_r == `PTR_HYST) begin
            readWord = hyst_r;
        end else if (rdSlot[4]) begin
            readWord = limit_r[rdSlot[3:0]];
        end
    end

    // Every write loads the pointer; reads answer from the pointer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reqSync1_r <= 1'b0;
            reqSync2_r <= 1'b0;
            reqSeen_r  <= 1'b0;
            ackTgl_r   <= 1'b0;
            pointer_r  <= `POINTER_RESET;
            rspWord_r  <= 16'h0000;
        end else begin
            reqSync1_r <= reqTgl_r;
            reqSync2_r <= reqSync1_r;
            if (cmdTake) begin
                reqSeen_r <= reqSync2_r;
                ackTgl_r  <= ~ackTgl_r;
                if (lWrite_r) begin
                    pointer_r <= lAddr_r;
                end else begin
                    rspWord_r <= readWord;
                end
            end
        end
    end

    // Writable registers; busy and reserved bits never store
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r  <= `CONFIG_RESET;
            hyst_r <= `HYST_RESET;
            for (int i = 0; i <= 8; i++) begin
                limit_r[i] <= `LIMIT_RESET;
            end
        end else if (wrTake) begin
            if (cfgWr) begin
                cfg_r <= {lData_r[15:2], 2'b00};
            end
            if (lAddr_r == `PTR_HYST) begin
                hyst_r <= lData_r;
            end
            if (wrSlot[4]) begin
                limit_r[wrSlot[3:0]] <= lData_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    assign en9       = {cfg_r[15:`CFG_REMOTE_LSB], cfg_r[`CFG_LOCAL_EN]};
    assign rate      = cfg_r[`CFG_RATE_LSB +: 3];
    assign anyEn     = |en9;
    assign runCont   = !cfg_r[`CFG_SHUTDOWN] && anyEn;
    assign abort     = !runCont && (!oneShotPass_r || !anyEn);
    assign startChan = firstFrom(en9, 4'h0);
    assign nextChan  = firstFrom(en9, chan_r + 4'h1);
    assign convDone  = (state_r == SEQ_CONV) && !abort && (cnt_r == 32'h1);
    assign startPass = ((state_r == SEQ_SHUT) && (runCont || (osPend_r && anyEn)))
                    || ((state_r == SEQ_IDLE) && !abort && (cnt_r == 32'h1))
                    || (convDone && (nextChan == 4'hF) && !oneShotPass_r
                        && (rate == `RATE_CONTINUOUS));
    assign startConv = startPass || (convDone && (nextChan != 4'hF));

    // One-shot request: set on write of shutdown and one-shot together
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            osPend_r <= 1'b0;
        end else if (cfgWr && lData_r[`CFG_SHUTDOWN] && lData_r[`CFG_ONESHOT]
                     && (|{lData_r[15:8], lData_r[`CFG_LOCAL_EN]})) begin
            osPend_r <= 1'b1;
        end else if (!anyEn || ((state_r == SEQ_SHUT) && startPass)) begin
            osPend_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Walks enabled channels, then idles for the selected interval
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r       <= SEQ_SHUT;
            chan_r        <= 4'h0;
            cnt_r         <= 32'h0;
            oneShotPass_r <= 1'b0;
        end else begin
            case (state_r)
                SEQ_SHUT: begin
                    if (startPass) begin
                        oneShotPass_r <= !runCont;
                    end
                end
                SEQ_CONV: begin
                    if (abort) begin
                        state_r <= SEQ_SHUT;
                    end else if (convDone && (nextChan == 4'hF)) begin
                        if (oneShotPass_r) begin
                            state_r       <= SEQ_SHUT;
                            oneShotPass_r <= 1'b0;
                        end else if (rate != `RATE_CONTINUOUS) begin
                            state_r <= SEQ_IDLE;
                            cnt_r   <= 32'(QUARTER_CYC) << (`RATE_QUARTER - rate);
                        end
                    end else if (!convDone) begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                SEQ_IDLE: begin
                    if (abort) begin
                        state_r <= SEQ_SHUT;
                    end else if (!startPass) begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                default: begin
                    state_r <= SEQ_SHUT;
                end
            endcase
            if (startConv) begin
                state_r <= SEQ_CONV;
                chan_r  <= startPass ? startChan : nextChan;
                cnt_r   <= convCycles(startPass ? startChan : nextChan);
            end
        end
    end

    // Front-end start pulse and channel select
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            feStart_r <= 1'b0;
            feChan    <= 4'h0;
        end else begin
            feStart_r <= startConv;
            if (startConv) begin
                feChan <= startPass ? startChan : nextChan;
            end
        end
    end

    assign feStart = feStart_r;

    // ----------------------------------------------------------------
    // Results, limit comparison and open flags
    // ----------------------------------------------------------------
    assign tempWord   = {feResult, 3'b000};
    assign clearLevel = {limit_r[chan_r][15], limit_r[chan_r]}
                      - {1'b0, 1'b0, hyst_r[15:8], 7'h00};
    assign overNow    = $signed(tempWord) > $signed(limit_r[chan_r]);
    assign underNow   = $signed({tempWord[15], tempWord}) <= $signed(clearLevel);

    // Flag of the finished channel: set above limit, clear below band
    always_comb begin
        flagsNxt = flags_r;
        if (convDone) begin
            if (overNow) begin
                flagsNxt[chan_r] = 1'b1;
            end else if (underNow) begin
                flagsNxt[chan_r] = 1'b0;
            end
        end
    end

    // Store result, flags and open state at conversion end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flags_r     <= 9'h000;
            openFlags_r <= 8'h00;
            for (int i = 0; i <= 8; i++) begin
                result_r[i] <= 13'h0000;
            end
        end else begin
            flags_r <= flagsNxt;
            if (convDone) begin
                result_r[chan_r] <= feResult;
                if (chan_r != 4'h0) begin
                    openFlags_r[chan_r] <= feOpen;
                end
            end
        end
    end

    // Output follows temperature flags only, never open flags
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            secondOvertempN_r <= 1'b1;
        end else begin
            secondOvertempN_r <= ~|flagsNxt;
        end
    end

    assign secondOvertempN = secondOvertempN_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Helper state for the checks below
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            age_r      <= 32'h0;
            doneChan_r <= 4'h0;
            enPrev_r   <= 9'h000;
        end else begin
            age_r      <= startConv ? 32'h0 : age_r + 32'h1;
            doneChan_r <= chan_r;
            enPrev_r   <= en9;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_out_flags;
        (|flags_r) == !secondOvertempN_r;
    endproperty
    a_out_flags: assert property (p_out_flags)
        else $error("overtemp output disagrees with flags");

    property p_abort;
        (state_r == SEQ_CONV && cfg_r[`CFG_SHUTDOWN] && !oneShotPass_r) |=> state_r == SEQ_SHUT;
    endproperty
    a_abort: assert property (p_abort)
        else $error("shutdown did not abort conversion");

    property p_restart_local;
        (state_r == SEQ_SHUT && runCont && en9[0]) |=> (state_r == SEQ_CONV && chan_r == 4'h0);
    endproperty
    a_restart_local: assert property (p_restart_local)
        else $error("restart did not begin at local channel");

    property p_skip;
        feStart_r |-> enPrev_r[feChan];
    endproperty
    a_skip: assert property (p_skip)
        else $error("disabled channel converted");

    property p_none_enabled;
        !anyEn |=> state_r == SEQ_SHUT;
    endproperty
    a_none_enabled: assert property (p_none_enabled)
        else $error("no enables but not shut down");

    property p_conv_len;
        convDone |-> age_r == convCycles(chan_r) - 32'h1;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");

    property p_oneshot_end;
        (convDone && oneShotPass_r && nextChan == 4'hF) |=> state_r == SEQ_SHUT;
    endproperty
    a_oneshot_end: assert property (p_oneshot_end)
        else $error("one-shot pass did not return to shutdown");

    property p_flag_set;
        (convDone && overNow) |=> flags_r[doneChan_r] && !secondOvertempN_r;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set above limit");

    property p_flag_clear;
        (convDone && underNow) |=> !flags_r[doneChan_r];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared below band");

    property p_result;
        convDone |=> result_r[doneChan_r] == $past(feResult);
    endproperty
    a_result: assert property (p_result)
        else $error("result not stored at conversion end");

    c_oneshot: cover property (convDone && oneShotPass_r && nextChan == 4'hF);
    c_wrap: cover property (convDone && nextChan == 4'hF && rate == `RATE_CONTINUOUS);
    c_flag: cover property (!secondOvertempN_r ##1 secondOvertempN_r);
    c_read: cover property (@(posedge linkClk) rspValid_r);

endmodule

//--- verilog/temp_seq_defs.svh
// Register map, field positions, reset values and timing for the
// nine-channel conversion sequencer.
// Assumes inclusion by the sequencer module only.
`ifndef TEMP_SEQ_DEFS_SVH
`define TEMP_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// Pointer values
// ----------------------------------------------------------------
`define PTR_RESULT_LAST   8'h08
`define PTR_LIMIT_STATUS  8'h22
`define PTR_OPEN_STATUS   8'h23
`define PTR_CONFIG        8'h30
`define PTR_HYST          8'h38
`define PTR_LOCAL_LIMIT   8'h3A
`define PTR_REMOTE_LIMIT1 8'h43
`define REMOTE_LIMIT_STEP 8'h08

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define POINTER_RESET     8'h00
`define CONFIG_RESET      16'h0F9C
`define HYST_RESET        16'h0A00
`define LIMIT_RESET       16'h4B00

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_REMOTE_LSB    8
`define CFG_LOCAL_EN      7
`define CFG_ONESHOT       6
`define CFG_SHUTDOWN      5
`define CFG_RATE_LSB      2
`define CFG_BUSY          1
`define RATE_CONTINUOUS   3'h7
`define RATE_QUARTER      3'h6

// ----------------------------------------------------------------
// Timing, in microseconds, and the clock rate
// ----------------------------------------------------------------
`define CLK_MHZ           200
`define LOC_CONV_US       15500
`define REM_CONV_US       15800
`define QUARTER_SEC_US    250000

`endif

//--- verilog/temp_seq_pkg.sv
// Types shared by the conversion sequencer.
// Assumes temp_seq_defs.svh is on the include path.
package temp_seq_pkg;
    // Sequencer phases: shut down, converting, idle between cycles
    typedef enum logic [1:0] {SEQ_SHUT, SEQ_CONV, SEQ_IDLE} seq_state_t;
endpackage

//--- verification/fe_model.sv
// Front-end model: hands back a programmed temperature and open flag
// for whichever channel the sequencer last started.
// Assumes the sequencer samples its inputs on core_clk.
module fe_model (
    input  wire logic        core_clk,
    input  wire logic        feStart,
    input  wire logic [3:0]  feChan,
    input  wire logic [8:0][12:0] temps,
    input  wire logic [8:0]  openMask,
    output logic [12:0]      feResult,
    output logic             feOpen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] chanR = 4'h0;
    // Remember the channel being converted
    always @(posedge core_clk) begin
        if (feStart) begin
            chanR <= feChan;
        end
    end
    // Result holds for the whole conversion
    assign feResult = temps[chanR];
    assign feOpen   = openMask[chanR];
endmodule

//--- verification/tb_top.sv
// Testbench of the conversion sequencer: host commands on linkClk,
// front-end model on core_clk.
// Assumes the package and the sequencer are compiled first.
module tb_top;
    import temp_seq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;
    logic        linkClk  = 1'b0;
    logic        rstn     = 1'b0;
    logic        cmdValid = 1'b0;
    logic        cmdWrite = 1'b0;
    logic        cmdPtrOnly = 1'b0;
    logic [7:0]  cmdAddr  = 8'h00;
    logic [15:0] cmdData  = 16'h0000;
    logic        cmdReady, rspValid, feStart, feOpen, secondOvertempN;
    logic [15:0] rspData, rdWord;
    logic [3:0]  feChan;
    logic [12:0] feResult;
    logic [8:0][12:0] temps;
    logic [8:0]  openMask = 9'h000;
    logic [3:0]  starts [$];
    int          n_fail = 0;
    int          num_checks = 0;
    int          gap = 0;
    int          lastGap = 0;
    // ----------------------------------------------------------------
    // Clocks, instances, monitor
    // ----------------------------------------------------------------
    initial forever #2.5 core_clk = ~core_clk;
    initial begin
        #3;
        forever #7.5 linkClk = ~linkClk;
    end
    temp_seq_ctrl #(.LOC_CONV_CYC(20), .REM_CONV_CYC(22), .QUARTER_CYC(10)) dut (
        .core_clk(core_clk), .rstn(rstn), .linkClk(linkClk), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdPtrOnly(cmdPtrOnly), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspData(rspData), .feStart(feStart), .feChan(feChan), .feResult(feResult),
        .feOpen(feOpen), .secondOvertempN(secondOvertempN));
    fe_model fe (.core_clk(core_clk), .feStart(feStart), .feChan(feChan),
        .temps(temps), .openMask(openMask), .feResult(feResult), .feOpen(feOpen));
    // Log started channels and spacing of starts
    always @(negedge core_clk) begin
        gap++;
        if (feStart === 1'b1) begin
            starts.push_back(feChan);
            lastGap = gap;
            gap = 0;
        end
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(logic wr, logic po, logic [7:0] a, logic [15:0] d);
        int n;
        n = 0;
        @(negedge linkClk);
        {cmdValid, cmdWrite, cmdPtrOnly, cmdAddr, cmdData} = {1'b1, wr, po, a, d};
        do begin
            @(posedge linkClk);
            n++;
        end while (cmdReady !== 1'b1 && n < 50);
        @(negedge linkClk);
        cmdValid = 1'b0;
        while (rspValid !== 1'b1 && n < 50) begin
            @(negedge linkClk);
            n++;
        end
        if (n >= 50) n_fail++;
        rdWord = rspData;
    endtask
    task automatic rd_chk(string what, logic [7:0] a, logic [15:0] exp);
        cmd(1'b1, 1'b1, a, 16'h0000);
        cmd(1'b0, 1'b0, 8'h00, 16'h0000);
        check(what, rdWord, exp);
    endtask
    // Remote 4 is the highest remote channel enabled after reset
    task automatic temps_wait(logic [12:0] t0, logic [12:0] t4);
        @(negedge core_clk);
        temps[0] = t0;
        temps[4] = t4;
        repeat (500) @(negedge core_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 9; i++) temps[i] = 13'h0400;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) rstn = 1'b1;
        rd_chk("config", 8'h30, 16'h0F9E);
        openMask = 9'h1FE;
        temps_wait(13'h0400, 13'h0400);
        rd_chk("open", 8'h23, 16'h0F00);
        check("otN open", {15'h0, secondOvertempN}, 16'h0001);
        rd_chk("flags", 8'h22, 16'h0000);
        $display("status test done");
        temps_wait(13'h0A00, 13'h0A00);
        rd_chk("flags hot", 8'h22, 16'h0880);
        check("otN hot", {15'h0, secondOvertempN}, 16'h0000);
        temps_wait(13'h08C8, 13'h08C0);
        rd_chk("flags hyst", 8'h22, 16'h0080);
        check("otN hyst", {15'h0, secondOvertempN}, 16'h0000);
        temps_wait(13'h08C0, 13'h08C0);
        rd_chk("flags cool", 8'h22, 16'h0000);
        check("otN cool", {15'h0, secondOvertempN}, 16'h0001);
        rd_chk("result", 8'h00, 16'h4600);
        $display("limit test done");
        cmd(1'b1, 1'b0, 8'h30, 16'h0FBC);
        starts.delete();
        repeat (300) @(negedge core_clk);
        check("shut starts", 16'(starts.size()), 16'h0000);
        rd_chk("shut config", 8'h30, 16'h0FBC);
        starts.delete();
        cmd(1'b1, 1'b0, 8'h30, 16'h029C);
        repeat (200) @(negedge core_clk);
        check("first chan", {12'h0, starts[0]}, 16'h0000);
        check("second chan", {12'h0, starts[1]}, 16'h0002);
        check("wrap chan", {12'h0, starts[2]}, 16'h0000);
        cmd(1'b1, 1'b0, 8'h30, 16'h001C);
        starts.delete();
        repeat (300) @(negedge core_clk);
        check("none starts", 16'(starts.size()), 16'h0000);
        cmd(1'b1, 1'b0, 8'h30, 16'h02BC);
        starts.delete();
        cmd(1'b1, 1'b0, 8'h30, 16'h02FC);
        repeat (300) @(negedge core_clk);
        check("pass starts", 16'(starts.size()), 16'h0002);
        check("pass chan", {12'h0, starts[1]}, 16'h0002);
        $display("mode test done");
        cmd(1'b1, 1'b0, 8'h30, 16'h009C);
        repeat (100) @(negedge core_clk);
        check("rate7 gap", 16'(lastGap), 16'h0014);
        cmd(1'b1, 1'b0, 8'h30, 16'h0098);
        repeat (200) @(negedge core_clk);
        check("rate6 idle", 16'(lastGap), 16'h001E);
        $display("rate test done");
        complete_run();
    end
endmodule
